// ===== design/irq_mask_trigger_consts.svh
// How it works
// - Normal nesting blocks every request below the highest in-service level.
// - Selective mask mode lets every unmasked level not in service request, nesting ignored.
// - Selective mask mode stays on until a clear command or reinit.
// - In that mode all masked levels leave requests and non-specific ends.
// - Non-specific end never clears a masked in-service bit in that mode.
// - Nothing but an acknowledge sets an in-service bit.
// - Configuration write picks level or edge request detection.
// - Level mode: a high line is a pending request, latch bypassed.
// - Level mode: line still high after end of service requests again.
// - No request at first strobe answers with default level seven.
// - Edge mode: only a low-to-high transition registers a request.
// - Edge mode: acknowledge disarms the latch until the line goes low.
// - Edge mode: a line already high gives no new request.
// - Automatic mode clears the in-service bit at sequence end.
// - Eight-bit mask acts only after the request register.
// - Non-specific end clears the highest-priority in-service bit, skipping masked bits in selective mask mode.
// - Priority is resolved every cycle; the vector is fixed at the first acknowledge strobe.
`ifndef IRQ_MASK_TRIGGER_CONSTS_SVH
`define IRQ_MASK_TRIGGER_CONSTS_SVH
`define CONFIG_OFS     4'h0
`define COMMAND_OFS    4'h4
`define MASK_OFS       4'h8
`define STATUS_OFS     4'hc
`define CFG_LEVEL_BIT  0
`define CFG_AUTO_BIT   1
`define CMD_OP_LSB     5
`define OP_EOS_ANY     3'h1
`define OP_EOS_LEVEL   3'h2
`define OP_SMM_SET     3'h3
`define OP_SMM_CLEAR   3'h4
`define DEFAULT_LEVEL  3'h7
`define MASK_RESET     8'h00
`endif

// ===== design/irq_mask_trigger_logic.sv
`timescale 1ns/1ps
`include "irq_mask_trigger_consts.svh"
module irq_mask_trigger_logic (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic [7:0]  request_line_i,
    input  wire logic        acknowledge_strobe_i,
    output logic             int_o,
    output logic [2:0]       vector_o
);

    irq_mask_trigger_pkg::imt_state_t st;
    irq_mask_trigger_pkg::imt_state_t next_st;

    // Lowest set index wins; returns {found, index}
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // Bits of strictly higher priority than index
    function automatic logic [7:0] above(input logic [3:0] f);
        logic [7:0] r;
        r = 8'hff;
        if (f[3])
        begin
            r = (8'h01 << f[2:0]) - 8'h01;
        end
        return r;
    endfunction

    logic [7:0] request_register;
    logic [7:0] pend;
    logic [7:0] isr_vis;
    logic [7:0] elig;
    logic [3:0] win;
    logic [3:0] top_vis;
    logic [3:0] top_isr;
    logic [7:0] steady;
    logic       first_rise;
    logic       second_rise;
    logic       bus_req;
    logic       wr_cfg;
    logic       wr_cmd;
    logic       wr_mask;
    logic [2:0] op;

    // Request register view and eligibility
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            request_register[i] = st.level_mode ? request_line_i[i]
                                   : (st.latch[i] & request_line_i[i]);
        end
        pend = request_register & ~st.mask_register;
        isr_vis = st.selective_mask_mode ? (st.in_service_register & ~st.mask_register)
                                         : st.in_service_register;
        top_isr = first_set(st.in_service_register);
        // Held-high lines with no latch: edge lockout must keep them idle
        steady = st.line_q & request_line_i & ~st.latch;
        if (st.selective_mask_mode)
        begin
            elig = pend & ~st.in_service_register;
        end
        else
        begin
            elig = pend & above(top_isr);
        end
        win = first_set(elig);
        top_vis = first_set(isr_vis);
        first_rise = acknowledge_strobe_i & ~st.strobe_q & (st.phase == irq_mask_trigger_pkg::WAIT_FIRST);
        second_rise = acknowledge_strobe_i & ~st.strobe_q & (st.phase == irq_mask_trigger_pkg::WAIT_SECOND);
    end

    // Bus strobes: a write lands on the edge where the master sees ack
    assign bus_req = cyc_i & stb_i;
    assign wr_cfg  = bus_req & we_i & st.wb_ack & sel_i[0] & (adr_i == `CONFIG_OFS);
    assign wr_cmd  = bus_req & we_i & st.wb_ack & sel_i[0] & (adr_i == `COMMAND_OFS);
    assign wr_mask = bus_req & we_i & st.wb_ack & sel_i[0] & (adr_i == `MASK_OFS);
    assign op      = dat_i[`CMD_OP_LSB +: 3];

    // Next state
    always_comb
    begin
        next_st = st;
        next_st.strobe_q = acknowledge_strobe_i;
        next_st.line_q = request_line_i;
        // Edge detection with lockout
        for (int i = 0; i < 8; i++)
        begin
            if (!request_line_i[i])
            begin
                next_st.armed[i] = 1'b1;
                next_st.latch[i] = 1'b0;
            end
            else if (!st.line_q[i] && st.armed[i])
            begin
                next_st.latch[i] = 1'b1;
            end
        end
        // Mask, mode and end-of-service commands
        if (wr_mask)
        begin
            next_st.mask_register = dat_i[7:0];
        end
        if (wr_cmd)
        begin
            if (op == `OP_SMM_SET)
            begin
                next_st.selective_mask_mode = 1'b1;
            end
            else if (op == `OP_SMM_CLEAR)
            begin
                next_st.selective_mask_mode = 1'b0;
            end
            else if (op == `OP_EOS_ANY && top_vis[3])
            begin
                next_st.in_service_register[top_vis[2:0]] = 1'b0;
            end
            else if (op == `OP_EOS_LEVEL)
            begin
                next_st.in_service_register[dat_i[2:0]] = 1'b0;
            end
        end
        // Acknowledge sequence; in-service set follows the end-of-service commands so it wins over their clear
        case (st.phase)
            irq_mask_trigger_pkg::WAIT_FIRST:
            begin
                if (first_rise)
                begin
                    next_st.phase = irq_mask_trigger_pkg::WAIT_SECOND;
                    next_st.cur_valid = win[3];
                    next_st.cur = win[3] ? win[2:0] : `DEFAULT_LEVEL;
                    next_st.vec = win[3] ? win[2:0] : `DEFAULT_LEVEL;
                    if (win[3])
                    begin
                        next_st.in_service_register[win[2:0]] = 1'b1;
                        next_st.latch[win[2:0]] = 1'b0;
                        next_st.armed[win[2:0]] = 1'b0;
                    end
                end
            end
            irq_mask_trigger_pkg::WAIT_SECOND:
            begin
                if (second_rise)
                begin
                    next_st.phase = irq_mask_trigger_pkg::WAIT_FIRST;
                    next_st.cur_valid = 1'b0;
                    if (st.auto_eos && st.cur_valid)
                    begin
                        next_st.in_service_register[st.cur] = 1'b0;
                    end
                end
            end
            default:
            begin
                next_st.phase = irq_mask_trigger_pkg::WAIT_FIRST;
            end
        endcase
        // Level mode re-requests by itself once the bit is gone
        next_st.intr = (elig != 8'h00);
        // Init word: trigger and automatic-end choice; mask, selective mask mode, in-service, latch and phase back to rest
        if (wr_cfg)
        begin
            next_st.level_mode = dat_i[`CFG_LEVEL_BIT];
            next_st.auto_eos = dat_i[`CFG_AUTO_BIT];
            next_st.selective_mask_mode = 1'b0;
            next_st.mask_register = `MASK_RESET;
            next_st.in_service_register = 8'h00;
            next_st.latch = 8'h00;
            next_st.phase = irq_mask_trigger_pkg::WAIT_FIRST;
            next_st.cur_valid = 1'b0;
        end
        // Wishbone slave: ack one cycle after the request, then drop
        next_st.wb_ack = bus_req & ~st.wb_ack;
        next_st.wb_dat = 32'h00000000;
        if (bus_req && !st.wb_ack && !we_i)
        begin
            if (adr_i == `CONFIG_OFS)
            begin
                next_st.wb_dat = {30'h0, st.auto_eos, st.level_mode};
            end
            else if (adr_i == `MASK_OFS)
            begin
                next_st.wb_dat = {24'h000000, st.mask_register};
            end
            else if (adr_i == `STATUS_OFS)
            begin
                next_st.wb_dat = {14'h0, st.intr, st.selective_mask_mode,
                                  st.in_service_register, request_register};
            end
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.mask_register <= `MASK_RESET;
            st.phase <= irq_mask_trigger_pkg::WAIT_FIRST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dat_o = st.wb_dat;
    assign ack_o = st.wb_ack;
    assign int_o = st.intr;
    assign vector_o = st.vec;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_nest;
        first_rise && !st.selective_mask_mode && st.in_service_register != 8'h00 && win[3]
            |-> win[2:0] < top_isr[2:0];
    endproperty
    a_nest: assert property (p_nest) else $error("lower level passed nesting");

    property p_smm_open;
        st.selective_mask_mode && !wr_cfg && (pend & ~st.in_service_register) != 8'h00
            |=> int_o;
    endproperty
    a_smm_open: assert property (p_smm_open) else $error("unmasked level blocked in smm");

    property p_smm_hold;
        st.selective_mask_mode && !wr_cfg && !(wr_cmd && op == `OP_SMM_CLEAR)
            |=> st.selective_mask_mode;
    endproperty
    a_smm_hold: assert property (p_smm_hold) else $error("smm dropped without command");

    property p_smm_invisible;
        st.selective_mask_mode && wr_cmd && op == `OP_EOS_ANY && !first_rise && !second_rise
            |=> (st.in_service_register & st.mask_register)
                == ($past(st.in_service_register) & $past(st.mask_register));
    endproperty
    a_smm_invisible: assert property (p_smm_invisible) else $error("masked bit cleared");

    property p_no_set;
        !first_rise |=> (st.in_service_register & ~$past(st.in_service_register)) == 8'h00;
    endproperty
    a_no_set: assert property (p_no_set) else $error("in-service set without ack");

    property p_default;
        first_rise && !win[3] |=> vector_o == `DEFAULT_LEVEL && !st.cur_valid;
    endproperty
    a_default: assert property (p_default) else $error("default level not given");

    property p_edge_lock;
        !st.level_mode && !wr_cfg && steady != 8'h00
            |=> (st.latch & $past(steady)) == 8'h00;
    endproperty
    a_edge_lock: assert property (p_edge_lock) else $error("steady line made request");

    property p_auto_eos;
        second_rise && st.auto_eos && st.cur_valid && !wr_cfg
            |=> !st.in_service_register[$past(st.cur)];
    endproperty
    a_auto_eos: assert property (p_auto_eos) else $error("auto end missed");

    // Outside selective mode the top in-service bit is always the one cleared
    property p_eos_any;
        !st.selective_mask_mode && wr_cmd && op == `OP_EOS_ANY && top_vis[3]
            |=> !st.in_service_register[$past(top_vis[2:0])];
    endproperty
    a_eos_any: assert property (p_eos_any) else $error("highest in-service bit kept");

    property p_win;
        first_rise && win[3] && !wr_cfg |=> st.in_service_register[$past(win[2:0])]
            && vector_o == $past(win[2:0]);
    endproperty
    a_win: assert property (p_win) else $error("winner not in service");

    property p_int;
        elig != 8'h00 |=> int_o;
    endproperty
    a_int: assert property (p_int) else $error("request output low");

    c_smm: cover property (st.selective_mask_mode && first_rise && win[3]);
    c_default: cover property (first_rise && !win[3]);
    c_auto: cover property (second_rise && st.auto_eos && st.cur_valid);
    c_level_again: cover property (st.level_mode && wr_cmd && op == `OP_EOS_LEVEL ##2 int_o);

endmodule // irq_mask_trigger_logic

// ===== design/irq_mask_trigger_pkg.sv
package irq_mask_trigger_pkg;
    typedef enum logic [0:0] {WAIT_FIRST, WAIT_SECOND} ack_phase_t;
    typedef struct packed {
        logic        level_mode;
        logic        auto_eos;
        logic        selective_mask_mode;
        logic [7:0]  mask_register;
        logic [7:0]  in_service_register;
        logic [7:0]  latch;
        logic [7:0]  armed;
        logic [7:0]  line_q;
        logic        strobe_q;
        ack_phase_t  phase;
        logic [2:0]  cur;
        logic        cur_valid;
        logic        intr;
        logic [2:0]  vec;
        logic        wb_ack;
        logic [31:0] wb_dat;
    } imt_state_t;
endpackage

// ===== sim/irq_ack_host.sv
`timescale 1ns/1ps
// Host side: two acknowledge strobes per sequence, a low gap between them
module irq_ack_host (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic go_i,
    input  wire logic slow_i,
    output logic      acknowledge_strobe_o,
    output logic      busy_o
);
    logic [2:0] step;
    logic       held;
    // Steps 1 and 3 strobe high; a slow host stretches the gap once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step <= 3'h0;
            held <= 1'b0;
        end
        else if (step == 3'h0)
        begin
            step <= go_i ? 3'h1 : 3'h0;
            held <= 1'b0;
        end
        else if (step == 3'h2 && slow_i && !held)
            held <= 1'b1;
        else
            step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
    end
    // Strobe decoded from a register, so it never glitches
    assign acknowledge_strobe_o = (step == 3'h1) || (step == 3'h3);
    assign busy_o               = (step != 3'h0);
endmodule // irq_ack_host

// ===== sim/irq_mask_trigger_logic_tb_top.sv
`timescale 1ns/1ps
`include "irq_mask_trigger_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module irq_mask_trigger_logic_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, slow = 1'b0, strobe, busy, ack_o, int_o;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, rd;
    logic [7:0]  line = 8'h00, m;
    logic [2:0]  vector_o;
    int          miscompares = 0, samples_checked = 0, r;
    always #50 clk_i = ~clk_i;
    irq_mask_trigger_logic dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .request_line_i(line),
        .acknowledge_strobe_i(strobe), .int_o(int_o), .vector_o(vector_o));
    irq_ack_host host_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow),
        .acknowledge_strobe_o(strobe), .busy_o(busy));
    // Highest-priority pending level, default level when none
    function automatic logic [2:0] win(input logic [7:0] q);
        for (int i = 0; i < 8; i++)
            if (q[i])
                return i[2:0];
        return `DEFAULT_LEVEL;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic cmd(input logic [2:0] op, input logic [2:0] lvl);
        wb(1'b1, `COMMAND_OFS, {24'h0, op, 2'b00, lvl});
    endtask
    task automatic set_line(input logic [7:0] v);
        @(posedge clk_i) line <= v;
        tick(4);
    endtask
    task automatic ack_seq;
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        do @(posedge clk_i); while (busy === 1'b1);
        tick(3);
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole run is about two hundred cycles; cut a hang well beyond that
    initial
    begin
        tick(20000);
        miscompares++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h7f3a));
        tick(20);
        rst_i <= 1'b0;
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd, 32'h0)
        wb(1'b0, `MASK_OFS, 32'h0); `CHK(rd, 32'h0)
        wb(1'b0, 4'h2, 32'h0); `CHK(rd, 32'h0)
        m = 8'($urandom);
        wb(1'b1, `MASK_OFS, {24'h0, m}); wb(1'b0, `MASK_OFS, 32'h0); `CHK(rd[7:0], m)
        // Edge mode, random level, line held high through the sequence
        wb(1'b1, `CONFIG_OFS, 32'h0);
        r = $urandom_range(6);
        set_line(8'h1 << r); `CHK(int_o, 1'b1)
        ack_seq(); `CHK(vector_o, win(8'h1 << r))
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[17:0], {2'b00, 8'h1 << r, 8'h00})
        set_line(8'h80 | (8'h1 << r)); `CHK(int_o, 1'b0)
        cmd(`OP_EOS_ANY, 3'h0); tick(3); `CHK(int_o, 1'b1)
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[15:0], 16'h0080)
        set_line(8'h80); set_line(8'h80 | (8'h1 << r));
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[7:0], 8'h80 | (8'h1 << r))
        set_line(8'h00); ack_seq(); `CHK(vector_o, `DEFAULT_LEVEL)
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[15:8], 8'h00)
        // Level mode with selective masking around a level in service
        wb(1'b1, `CONFIG_OFS, 32'h1);
        set_line(8'h10); ack_seq(); `CHK(vector_o, 3'h4)
        set_line(8'h50); `CHK(int_o, 1'b0)
        wb(1'b1, `MASK_OFS, 32'h10); cmd(`OP_SMM_SET, 3'h0); tick(3);
        `CHK(int_o, 1'b1)
        wb(1'b1, `MASK_OFS, 32'h50); tick(3); `CHK(int_o, 1'b0)
        wb(1'b1, `MASK_OFS, 32'h10); cmd(`OP_EOS_ANY, 3'h0); tick(3);
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[16:8], 9'h110)
        cmd(`OP_SMM_CLEAR, 3'h0); wb(1'b1, `MASK_OFS, 32'h0);
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[16], 1'b0)
        cmd(`OP_EOS_LEVEL, 3'h4); tick(3); `CHK(int_o, 1'b1)
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[15:0], 16'h0050)
        // Automatic end with a slow host; level still high requests again
        set_line(8'h00); wb(1'b1, `CONFIG_OFS, 32'h3);
        slow <= 1'b1; set_line(8'h04); ack_seq(); `CHK(vector_o, 3'h2)
        wb(1'b0, `STATUS_OFS, 32'h0); `CHK(rd[15:8], 8'h00)
        `CHK(int_o, 1'b1)
        end_sim();
    end
endmodule // irq_mask_trigger_logic_tb_top
